// ==== bench/mrc_phy_model.sv ====
// PHY byte source and fifo controller sink for the receive control block
`timescale 1ns/100ps
module mrc_phy_model (
    // Clock
    input wire logic sys_clk,
    // PHY stream
    output logic phy_rx_dv,
    output logic phy_rx_er,
    output logic [7:0] phy_rx_data,
    // Fifo controller side
    input wire logic fifo_valid,
    input wire logic [7:0] fifo_data,
    input wire logic rx_status_valid,
    input wire logic [31:0] rx_status_word,
    // Observed totals
    output int byte_cnt,
    output int stat_cnt,
    output logic [31:0] last_word,
    output int err_cnt
);
    logic [7:0] sent [0:16383];
    int rd_idx;
    initial begin
        phy_rx_dv = 1'b0;
        phy_rx_er = 1'b0;
        phy_rx_data = 8'hA5;
        byte_cnt = 0;
        stat_cnt = 0;
        err_cnt = 0;
        rd_idx = 0;
        last_word = 32'h0;
    end
    task automatic send(input int len, input int tags, input int er_at);
        logic [7:0] b;
        rd_idx = 0;
        for (int i = 1; i <= len; i++) begin
            b = i[7:0] ^ 8'h3C;
            if ((tags > 0 && i == 13) || (tags > 1 && i == 17)) b = 8'h81;
            if ((tags > 0 && i == 14) || (tags > 1 && i == 18)) b = 8'h00;
            sent[i-1] = b;
            @(posedge sys_clk);
            phy_rx_dv <= 1'b1;
            phy_rx_er <= (i == er_at);
            phy_rx_data <= b;
        end
        // Idle line shows the inverse so a stale byte cannot pass
        @(posedge sys_clk);
        phy_rx_dv <= 1'b0;
        phy_rx_er <= 1'b0;
        phy_rx_data <= ~b;
    endtask
    // Fifo controller always takes; bytes must arrive in order
    always @(posedge sys_clk) begin
        if (fifo_valid === 1'b1) begin
            if (fifo_data !== sent[rd_idx]) err_cnt++;
            rd_idx++;
            byte_cnt++;
        end
        if (rx_status_valid === 1'b1) begin
            stat_cnt++;
            last_word = rx_status_word;
        end
    end
endmodule

// ==== bench/mrc_rx_ctrl_tb_top.sv ====
// Self-checking testbench for the receive control block
`timescale 1ns/100ps
module mrc_rx_ctrl_tb_top;
    import mrc_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hF;
    wire logic awready, wready, bvalid, arready, rvalid, dv, er, fv, sv, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, sw;
    wire logic [7:0] pd, fd;
    int bytes, stats, errs;
    int fails = 0;
    int comparisons = 0;
    logic [31:0] word;
    logic [1:0] rsp;
    always #5 sys_clk = ~sys_clk;
    mrc_rx_ctrl i_dut (.sys_clk(sys_clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .phy_rx_dv(dv), .phy_rx_er(er), .phy_rx_data(pd),
        .fifo_valid(fv), .fifo_data(fd), .rx_status_valid(sv), .rx_status_word(sw),
        .irq(irq));
    mrc_phy_model i_phy (.sys_clk(sys_clk), .phy_rx_dv(dv), .phy_rx_er(er),
        .phy_rx_data(pd), .fifo_valid(fv), .fifo_data(fd), .rx_status_valid(sv),
        .rx_status_word(sw), .byte_cnt(bytes), .stat_cnt(stats), .last_word(word),
        .err_cnt(errs));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Ready is sampled at the falling edge, where it is settled
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic ah, wh, bh;
        bh = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int n = 0; n < 50 && !bh; n++) begin
            @(negedge sys_clk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid;
            rsp = bresp;
            @(posedge sys_clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        chk(bh, 1'b1);
    endtask
    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] resp);
        logic ah, rh;
        logic [31:0] v;
        rh = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 50 && !rh; n++) begin
            @(negedge sys_clk);
            ah = arvalid & arready;
            rh = rvalid;
            v = rdata;
            rsp = rresp;
            @(posedge sys_clk);
            if (ah) arvalid <= 1'b0;
        end
        chk(rh, 1'b1);
        chk(v, exp);
        chk(rsp, resp);
    endtask
    // Receiver is switched off while settings change, then flag cleared
    task cfg(input logic [13:0] mx, input logic ts, input logic st, input logic vl);
        logic [31:0] v;
        v = (32'(mx) << CTRL_MAX_LO) | (32'(ts) << CTRL_TSEL) | (32'(st) << CTRL_STRIP)
            | (32'(vl) << CTRL_VLAN);
        wr(OFS_CTRL, v);
        wr(OFS_CTRL, v | 32'h3);
    endtask
    task frame(input int len, input int tags, input int er_at, input int exp_len,
        input int exp_n, input logic [2:0] fl, input logic exp_s);
        int b0, s0;
        b0 = bytes;
        s0 = stats;
        i_phy.send(len, tags, er_at);
        repeat (3) @(posedge sys_clk);
        chk(bytes - b0, exp_n);
        chk(stats - s0, 32'(exp_s));
        if (exp_s) chk(word, {13'h0, fl, 2'b00, exp_len[13:0]});
        chk(errs, 0);
    endtask
    task complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        fork
            begin
                repeat (80000) @(posedge sys_clk);
                fails++;
                $display("Watchdog expired");
                complete_run();
            end
        join_none
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk(irq, 0);
        rd_chk(OFS_CTRL, 32'h05EE_0020, RESP_OKAY);
        rd_chk(OFS_IMASK, 32'h0, RESP_OKAY);
        rd_chk(12'h200, 32'h0, RESP_SLVERR);
        wr(12'h200, 32'hFFFF_FFFF);
        chk(rsp, RESP_SLVERR);
        wr(OFS_CTRL, 32'hC5EE_FFE8);
        rd_chk(OFS_CTRL, 32'h05EE_0020, RESP_OKAY);
        // Only byte lane 2 written: low byte of the maximum size
        wstrb <= 4'h4;
        wr(OFS_CTRL, 32'h0000_0000);
        wstrb <= 4'hF;
        chk(rsp, RESP_OKAY);
        rd_chk(OFS_CTRL, 32'h0500_0020, RESP_OKAY);
        frame(10, 0, 0, 0, 0, 3'b000, 1'b0);
        $display("Test registers done");
        cfg(14'd100, 1'b0, 1'b0, 1'b0);
        frame(60, 0, 0, 60, 60, 3'b000, 1'b1);
        frame(120, 0, 0, 101, 101, 3'b101, 1'b1);
        frame(60, 0, 30, 60, 60, 3'b100, 1'b1);
        cfg(14'd100, 1'b0, 1'b1, 1'b0);
        frame(60, 0, 0, 60, 56, 3'b000, 1'b1);
        cfg(14'd100, 1'b0, 1'b0, 1'b1);
        frame(104, 1, 0, 104, 104, 3'b000, 1'b1);
        frame(106, 1, 0, 105, 105, 3'b101, 1'b1);
        frame(108, 2, 0, 108, 108, 3'b000, 1'b1);
        frame(110, 2, 0, 109, 109, 3'b101, 1'b1);
        frame(102, 0, 0, 101, 101, 3'b101, 1'b1);
        cfg(14'd100, 1'b0, 1'b0, 1'b0);
        frame(104, 1, 0, 101, 101, 3'b101, 1'b1);
        $display("Test size limits done");
        cfg(14'd100, 1'b1, 1'b0, 1'b0);
        frame(120, 0, 0, 120, 120, 3'b001, 1'b1);
        frame(11300, 0, 0, 11265, 11265, 3'b111, 1'b1);
        cfg(14'h3FFF, 1'b0, 1'b0, 1'b0);
        frame(11300, 0, 0, 11265, 11265, 3'b111, 1'b1);
        $display("Test watchdog done");
        rd_chk(OFS_ISTS, 32'hF, RESP_OKAY);
        chk(irq, 0);
        wr(OFS_IMASK, 32'h4);
        chk(irq, 1);
        wr(OFS_ISTS, 32'h4);
        chk(irq, 0);
        rd_chk(OFS_ISTS, 32'hB, RESP_OKAY);
        $display("Test interrupts done");
        cfg(14'h05EE, 1'b1, 1'b0, 1'b0);
        wr(OFS_ISTS, 32'hF);
        wr(OFS_IMASK, 32'h8);
        fork
            frame(200, 0, 0, 200, 200, 3'b000, 1'b1);
            begin
                repeat (30) @(posedge sys_clk);
                wr(OFS_CTRL, 32'h05EE_0020);
                rd_chk(OFS_CTRL, 32'h05EE_0020, RESP_OKAY);
                chk(irq, 0);
            end
        join
        rd_chk(OFS_CTRL, 32'h05EE_0022, RESP_OKAY);
        chk(irq, 1);
        wr(OFS_CTRL, 32'h05EE_0022);
        rd_chk(OFS_CTRL, 32'h05EE_0020, RESP_OKAY);
        frame(20, 0, 0, 0, 0, 3'b000, 1'b0);
        wr(OFS_ISTS, 32'hF);
        chk(irq, 0);
        $display("Test disable done");
        complete_run();
    end
endmodule

// ==== rtl/mrc_axil_slave.sv ====
// AXI4-Lite slave front end turning bus cycles into register strobes
`timescale 1ns/100ps
module mrc_axil_slave
    import mrc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Register side
    output logic wr_en,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    logic aw_full_r;
    logic w_full_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;

    // Either channel may arrive first; each is held until both are in
    assign s_axi_awready = ~aw_full_r & ~bvalid_r;
    assign s_axi_wready = ~w_full_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign wr_en = aw_full_r & w_full_r & ~bvalid_r;
    assign wr_addr = awaddr_r;
    assign wr_data = wdata_r;
    assign wr_strb = wstrb_r;
    assign rd_addr = s_axi_araddr;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_take) begin
                aw_full_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_full_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_hit ? rd_data : 32'h00000000;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// ==== rtl/mrc_pkg.sv ====
// Constants shared by the receive control block and its register slave
package mrc_pkg;
    localparam int ADDR_W = 12;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h104;
    localparam logic [11:0] OFS_ISTS = 12'h120;
    localparam logic [11:0] OFS_IMASK = 12'h124;
    // Control register field positions
    localparam int CTRL_ON = 0;
    localparam int CTRL_DIS = 1;
    localparam int CTRL_VLAN = 2;
    localparam int CTRL_STRIP = 4;
    localparam int CTRL_TSEL = 5;
    localparam int CTRL_MAX_LO = 16;
    localparam int CTRL_MAX_HI = 29;
    // Values after reset
    localparam logic [13:0] MAX_RST = 14'h05EE;
    localparam logic TSEL_RST = 1'b1;
    localparam logic [3:0] IMASK_RST = 4'h0;
    // Frame limits and layout
    localparam logic [13:0] WDOG_CUT = 14'h2C01;
    localparam logic [14:0] VLAN_ADD = 15'h0004;
    localparam logic [2:0] FCS_BYTES = 3'h4;
    localparam logic [15:0] TPID_C = 16'h8100;
    localparam logic [15:0] TPID_S = 16'h88A8;
    localparam logic [13:0] TYPE1_IDX = 14'h000E;
    localparam logic [13:0] TYPE2_IDX = 14'h0012;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_LONG = 1;
    localparam int IRQ_WDOG = 2;
    localparam int IRQ_DIS = 3;
    // Status word field positions
    localparam int SW_LONG = 16;
    localparam int SW_WDOG = 17;
    localparam int SW_FCS = 18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MRC_IDLE = 2'b00,
        MRC_RECV = 2'b01,
        MRC_DROP = 2'b10
    } mrc_state_e;
endpackage

// ==== rtl/mrc_rx_ctrl.sv ====
// Receive control of the MAC: size limits, watchdog cut, FCS strip, disable
//
// Summary of operation
// [R1] Frames longer than the 14-bit maximum size (reset 1518) are flagged long.
// [R2] The watchdog cuts and aborts every frame longer than 11264 bytes.
// [R3] Select bit 0: cut at maximum plus one, status shows long and length.
// [R4] Select bit 1 (reset): cut at 11265, status shows long, 11265, watchdog.
// [R5] With strip set the last 4 bytes of each frame are dropped; resets off.
// [R6] Enforcement clear: one limit, the maximum size, for every frame.
// [R7] Enforcement set: limit grows by 4 per VLAN tag, up to two tags.
// [R8] Falling enable sets the sticky disabled flag once disabling completes.
// [R9] Frames are accepted only while the enable bit is set; resets clear.
// [R10] A frame in progress when enable clears is finished before disabling.
// [R11] Software keeps the size, cut, strip and VLAN settings still while enabled.
// [R12] Reserved control bits read as zero and ignore writes.
`timescale 1ns/100ps
module mrc_rx_ctrl
    import mrc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // AXI4-Lite register bus
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // PHY receive byte stream
    input wire logic phy_rx_dv,
    input wire logic phy_rx_er,
    input wire logic [7:0] phy_rx_data,
    // Towards the fifo controller
    output logic fifo_valid,
    output logic [7:0] fifo_data,
    output logic rx_status_valid,
    output logic [31:0] rx_status_word,
    // Interrupt
    output logic irq
);
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) old[i*8 +: 8] = d[i*8 +: 8];
        end
        return old;
    endfunction

    logic receiver_on_r;
    logic on_prev_r;
    logic rx_dis_r;
    logic dis_pend_r;
    logic vlan_size_enforce_r;
    logic fcs_strip_r;
    logic truncation_length_select_r;
    logic [13:0] max_size_r;
    logic [3:0] ists_r;
    logic [3:0] imask_r;
    mrc_state_e state_r;
    mrc_state_e state_nxt;
    logic dv_prev_r;
    logic [13:0] cnt_r;
    logic [7:0] type_hi_r;
    logic [1:0] tags_r;
    logic long_r;
    logic err_r;
    logic [7:0] dl_r [0:3];
    logic [2:0] held_r;
    logic out_valid_r;
    logic [7:0] out_data_r;
    logic stat_valid_r;
    logic [31:0] stat_r;

    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_hit;
    logic rd_hit;

    mrc_axil_slave u_bus (
        .sys_clk(sys_clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
        .wr_hit(wr_hit), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit)
    );

    // Register decode and read image
    wire wr_ctrl = wr_en && (wr_addr == OFS_CTRL);
    wire wr_ists = wr_en && (wr_addr == OFS_ISTS);
    wire wr_imask = wr_en && (wr_addr == OFS_IMASK);
    assign wr_hit = (wr_addr == OFS_CTRL) || (wr_addr == OFS_ISTS) || (wr_addr == OFS_IMASK);
    assign rd_hit = (rd_addr == OFS_CTRL) || (rd_addr == OFS_ISTS) || (rd_addr == OFS_IMASK);
    wire [31:0] ctrl_img = {2'h0, max_size_r, 10'h000, truncation_length_select_r,
                            fcs_strip_r, 1'b0, vlan_size_enforce_r, rx_dis_r,
                            receiver_on_r}; // R12
    wire [31:0] ctrl_w = wmerge(32'h00000000, wr_data, wr_strb);
    wire [31:0] ctrl_new = wmerge(ctrl_img, wr_data, wr_strb);
    wire [31:0] ists_w = wmerge(32'h00000000, wr_data, wr_strb);
    wire [31:0] imask_new = wmerge({28'h0000000, imask_r}, wr_data, wr_strb);
    assign rd_data = (rd_addr == OFS_CTRL) ? ctrl_img :
                     (rd_addr == OFS_ISTS) ? {28'h0000000, ists_r} :
                     (rd_addr == OFS_IMASK) ? {28'h0000000, imask_r} : 32'h00000000;

    // Frame size limits
    wire [14:0] limit = {1'b0, max_size_r} +
                        (vlan_size_enforce_r ? VLAN_ADD * {13'h0000, tags_r} : 15'h0000); // R6 R7
    wire [14:0] cut_len = truncation_length_select_r ? {1'b0, WDOG_CUT} :
                          limit + 15'h0001; // R3 R4
    wire start = (state_r == MRC_IDLE) && phy_rx_dv && !dv_prev_r && receiver_on_r; // R9
    wire take = start || ((state_r == MRC_RECV) && phy_rx_dv);
    wire [13:0] cnt_nxt = start ? 14'h0001 : cnt_r + 14'h0001;
    wire wdog_hit = take && (cnt_nxt == WDOG_CUT); // R2
    wire cut = take && (({1'b0, cnt_nxt} == cut_len) || wdog_hit);
    // Cleared at start so a long frame cannot mark the next; watchdog cut is always long
    wire long_nxt = (!start && long_r) || ({1'b0, cnt_nxt} > limit) || wdog_hit; // R1
    wire end_ok = (state_r == MRC_RECV) && !phy_rx_dv;
    wire frame_end = end_ok || cut;
    wire [15:0] type_pair = {type_hi_r, phy_rx_data};
    wire is_tpid = (type_pair == TPID_C) || (type_pair == TPID_S);
    wire fell_on = on_prev_r && !receiver_on_r;
    wire dis_set = (fell_on || dis_pend_r) && (state_r == MRC_IDLE); // R10
    wire [3:0] ev = {dis_set, wdog_hit, cut && long_nxt, frame_end};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MRC_IDLE: begin
                if (start) state_nxt = cut ? MRC_DROP : MRC_RECV;
            end
            MRC_RECV: begin
                if (!phy_rx_dv) state_nxt = MRC_IDLE;
                else if (cut) state_nxt = MRC_DROP;
            end
            MRC_DROP: begin
                if (!phy_rx_dv) state_nxt = MRC_IDLE;
            end
            default: state_nxt = MRC_IDLE;
        endcase
    end

    // Software registers; hardware set wins over software clear
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            receiver_on_r <= 1'b0;
            vlan_size_enforce_r <= 1'b0;
            fcs_strip_r <= 1'b0;
            truncation_length_select_r <= TSEL_RST;
            max_size_r <= MAX_RST;
            imask_r <= IMASK_RST;
        end else begin
            if (wr_ctrl) begin
                receiver_on_r <= ctrl_new[CTRL_ON];
                vlan_size_enforce_r <= ctrl_new[CTRL_VLAN];
                fcs_strip_r <= ctrl_new[CTRL_STRIP];
                truncation_length_select_r <= ctrl_new[CTRL_TSEL];
                max_size_r <= ctrl_new[CTRL_MAX_HI:CTRL_MAX_LO];
            end
            if (wr_imask) imask_r <= imask_new[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            on_prev_r <= 1'b0;
            rx_dis_r <= 1'b0;
            dis_pend_r <= 1'b0;
            ists_r <= 4'h0;
        end else begin
            on_prev_r <= receiver_on_r;
            rx_dis_r <= dis_set | (rx_dis_r & ~(wr_ctrl & ctrl_w[CTRL_DIS])); // R8
            dis_pend_r <= (dis_pend_r | fell_on) & ~dis_set & ~receiver_on_r;
            ists_r <= ev | (ists_r & ~(wr_ists ? ists_w[3:0] : 4'h0));
        end
    end
    assign irq = |(ists_r & imask_r);

    // Frame tracking
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= MRC_IDLE;
            dv_prev_r <= 1'b0;
            cnt_r <= 14'h0000;
            type_hi_r <= 8'h00;
            tags_r <= 2'h0;
            long_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            dv_prev_r <= phy_rx_dv;
            if (take) begin
                cnt_r <= cnt_nxt;
                long_r <= long_nxt;
                err_r <= (start ? 1'b0 : err_r) | phy_rx_er;
                type_hi_r <= phy_rx_data;
                if (start) begin
                    tags_r <= 2'h0;
                end else if (cnt_nxt == TYPE1_IDX && is_tpid) begin
                    tags_r <= 2'h1; // R7
                end else if (cnt_nxt == TYPE2_IDX && is_tpid && tags_r == 2'h1) begin
                    tags_r <= 2'h2; // R7
                end
            end
        end
    end

    // Output path; four bytes held back while stripping
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            held_r <= 3'h0;
            out_valid_r <= 1'b0;
            out_data_r <= 8'h00;
            for (int i = 0; i < 4; i++) dl_r[i] <= 8'h00;
        end else begin
            out_valid_r <= take && (!fcs_strip_r || held_r == FCS_BYTES); // R5
            out_data_r <= fcs_strip_r ? dl_r[3] : phy_rx_data; // R5
            if (take) begin
                dl_r[0] <= phy_rx_data;
                for (int i = 1; i < 4; i++) dl_r[i] <= dl_r[i-1];
            end
            if (frame_end) held_r <= 3'h0;
            else if (take && held_r != FCS_BYTES) held_r <= held_r + 3'h1;
        end
    end

    // Status word handed over at the cut or at the end of the frame
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat_valid_r <= 1'b0;
            stat_r <= 32'h00000000;
        end else begin
            stat_valid_r <= frame_end;
            if (frame_end) begin
                stat_r <= 32'h00000000;
                stat_r[13:0] <= cut ? cnt_nxt : cnt_r; // R3 R4
                stat_r[SW_LONG] <= cut ? long_nxt : long_r; // R1
                stat_r[SW_WDOG] <= wdog_hit; // R4
                // Cut frames lose their FCS, so they report an FCS error
                stat_r[SW_FCS] <= cut | err_r | (take & phy_rx_er);
            end
        end
    end
    assign fifo_valid = out_valid_r;
    assign fifo_data = out_data_r;
    assign rx_status_valid = stat_valid_r;
    assign rx_status_word = stat_r;

    // Checks
    logic [13:0] out_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (srst || stat_valid_r) out_cnt_r <= 14'h0000;
        else if (out_valid_r) out_cnt_r <= out_cnt_r + 14'h0001;
    end
    wire [13:0] out_tot = out_cnt_r + {13'h0000, out_valid_r};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_off_no_frame: assert property (state_r == MRC_IDLE && !receiver_on_r |=> // R9
        state_r == MRC_IDLE && !fifo_valid) else $error("frame accepted while off");
    a_cut_at_max: assert property (stat_valid_r && stat_r[SW_FCS] && !stat_r[SW_WDOG] && // R3
        !$past(truncation_length_select_r) && !$past(vlan_size_enforce_r) &&
        !$past(err_r) && stat_r[13:0] > max_size_r |->
        stat_r[13:0] == max_size_r + 14'h0001 && stat_r[SW_LONG])
        else $error("bad cut at max plus one");
    a_wdog_status: assert property (stat_valid_r && stat_r[SW_WDOG] |-> // R4
        stat_r[13:0] == WDOG_CUT && stat_r[SW_LONG] && stat_r[SW_FCS])
        else $error("bad watchdog status");
    a_wdog_bound: assert property (stat_valid_r |-> stat_r[13:0] <= WDOG_CUT) // R2
        else $error("frame beyond watchdog length");
    a_long_flag: assert property (stat_valid_r && !vlan_size_enforce_r && // R1 R6
        stat_r[13:0] > max_size_r |-> stat_r[SW_LONG]) else $error("long flag missing");
    sequence s_strip_end;
        stat_valid_r && fcs_strip_r && stat_r[13:0] >= 14'h0004;
    endsequence
    a_strip_count: assert property (s_strip_end |-> // R5
        out_tot + 14'h0004 == stat_r[13:0]) else $error("strip count wrong");
    sequence s_off_idle;
        $fell(receiver_on_r) ##0 state_r == MRC_IDLE;
    endsequence
    a_dis_flag: assert property (s_off_idle |=> rx_dis_r) // R8
        else $error("disabled flag not set");
    a_dis_waits: assert property ($rose(rx_dis_r) |-> $past(state_r) == MRC_IDLE) // R10
        else $error("disabled during a frame");
    a_reserved_zero: assert property (s_axi_arvalid && s_axi_arready && rd_addr == OFS_CTRL |=> // R12
        s_axi_rdata[31:30] == 2'h0 && s_axi_rdata[15:6] == 10'h000 && !s_axi_rdata[3])
        else $error("reserved bit set");
    a_drop_quiet: assert property (state_r == MRC_DROP ##1 state_r == MRC_DROP |-> // R2
        !fifo_valid) else $error("bytes passed after cut");
endmodule
